// ===== rtl/crf_rx_fifo_filter.sv
// receive fifo with output mailbox and six scalable acceptance filter banks, apb slave
`timescale 1ns/1ps
module crf_rx_fifo_filter
   import crf_pkg::*;
(
   input  wire logic              REF_CLK,
   input  wire logic              RST_N,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              FRM_VALID,
   input  wire crf_frame_type     FRM_IN,
   output logic                   IRQ_PENDING,
   output logic                   IRQ_FULL,
   output logic                   IRQ_OVERRUN
);
   // ******************************************************
   // helper functions
   // ******************************************************
   function automatic logic [31:0] swap_bytes(input logic [31:0] w);
      swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : swap_bytes
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit
   // one mask/list pair of 8 or 16 significant bits
   function automatic logic pair_match(input logic [15:0] f, input logic [15:0] id,
                                       input logic [15:0] m, input logic [15:0] care,
                                       input logic list);
      if (list)
         pair_match = (((f ^ id) & care) == 16'h0000) || (((f ^ m) & care) == 16'h0000);
      else
         pair_match = ((f ^ id) & m & care) == 16'h0000;
   endfunction : pair_match
   // half bank: bytes b = {Ra, Rb, Rc, Rd}, wide picks one 16-bit filter else two 8-bit
   function automatic logic half_match(input logic [31:0] b, input logic list,
                                       input logic wide, input logic [15:0] f16,
                                       input logic [15:0] care16);
      logic [15:0] f8;
      f8 = {8'h00, f16[15:8]};
      if (wide)
         half_match = pair_match(f16, b[31:16], b[15:0], care16, list);
      else
         half_match = pair_match(f8, {8'h00, b[31:24]}, {8'h00, b[23:16]}, 16'h00FF, list)
                   || pair_match(f8, {8'h00, b[15:8]}, {8'h00, b[7:0]}, 16'h00FF, list);
   endfunction : half_match
   function automatic logic bank_match(input logic [63:0] b, input crf_scale_type sc,
                                       input logic lo_list, input logic hi_list,
                                       input logic [31:0] f32, input logic [31:0] care32);
      logic [15:0] f16;
      logic [15:0] c16;
      f16 = f32[31:16];
      c16 = care32[31:16];
      case (sc)
         SCALE_ONE32 :
         begin
            if (lo_list)
               bank_match = (((f32 ^ b[63:32]) & care32) == ZERO32)
                         || (((f32 ^ b[31:0]) & care32) == ZERO32);
            else
               bank_match = ((f32 ^ b[63:32]) & b[31:0] & care32) == ZERO32;
         end
         SCALE_TWO16 :
            bank_match = half_match(b[63:32], lo_list, 1'b1, f16, c16)
                      || half_match(b[31:0], hi_list, 1'b1, f16, c16);
         SCALE_MIXED :
            bank_match = half_match(b[63:32], lo_list, 1'b1, f16, c16)
                      || half_match(b[31:0], hi_list, 1'b0, f16, c16);
         SCALE_FOUR8 :
            bank_match = half_match(b[63:32], lo_list, 1'b0, f16, c16)
                      || half_match(b[31:0], hi_list, 1'b0, f16, c16);
         default :
            bank_match = 1'b0;
      endcase
   endfunction : bank_match

   // ******************************************************
   // registers
   // ******************************************************
   crf_bus_state_type bus_state_reg;
   logic              lock_reg;
   logic [2:0]        ier_reg;
   logic              full_flag_reg;
   logic              overrun_flag_reg;
   logic [NUM_BANKS-1:0] bank_active_reg;
   crf_scale_type     bank_scale_reg [NUM_BANKS];
   logic [NUM_BANKS-1:0] low_list_reg;
   logic [NUM_BANKS-1:0] high_list_reg;
   logic [63:0]       filter_bytes_reg [NUM_BANKS];  // in [63:56] .. in [7:0]
   crf_frame_type     entry_reg [FIFO_DEPTH];
   logic [1:0]        count_reg;

   // ******************************************************
   // apb decode
   // ******************************************************
   wire               access_done = PSEL && PENABLE && PREADY;
   wire               wr_done     = access_done && PWRITE;
   wire               filt_hit    = (PADDR[11:6] == FILT_REGION) && (PADDR[5:3] < 3'h6)
                                    && (PADDR[1:0] == 2'h0);
   wire [2:0]         filt_bank   = PADDR[5:3];
   wire               filt_word   = PADDR[2];
   wire [63:0]        sel_bytes   = filter_bytes_reg[filt_bank];
   wire               release_cmd = wr_done && hit(PADDR, OFF_RFR) && PWDATA[RFR_REL_BIT];
   wire               reg_hit     = hit(PADDR, OFF_MCR) || hit(PADDR, OFF_IER)
                                    || hit(PADDR, OFF_RFR) || hit(PADDR, OFF_FCR)
                                    || hit(PADDR, OFF_FMR) || hit(PADDR, OFF_MB_ID)
                                    || hit(PADDR, OFF_MB_DLC) || hit(PADDR, OFF_MB_DLO)
                                    || hit(PADDR, OFF_MB_DHI) || filt_hit;
   logic [31:0]       fcr_word;
   logic [31:0]       rd_data;
   crf_frame_type     head;

   assign head = entry_reg[0];

   always_comb
   begin
      fcr_word = ZERO32;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         fcr_word[b*FCR_STRIDE]      = bank_active_reg[b];
         fcr_word[b*FCR_STRIDE + 1]  = bank_scale_reg[b][0];
         fcr_word[b*FCR_STRIDE + 2]  = bank_scale_reg[b][1];
      end
   end

   assign rd_data =
      hit(PADDR, OFF_MCR)    ? {31'h0000_0000, lock_reg} :
      hit(PADDR, OFF_IER)    ? {29'h0000_0000, ier_reg} :
      hit(PADDR, OFF_RFR)    ? {27'h0000_0000, overrun_flag_reg, full_flag_reg, 1'b0,
                                count_reg} :
      hit(PADDR, OFF_FCR)    ? fcr_word :
      hit(PADDR, OFF_FMR)    ? {18'h00000, high_list_reg, 2'h0, low_list_reg} :
      hit(PADDR, OFF_MB_ID)  ? {1'b0, head.ide, head.rtr, head.base_identifier,
                                head.extended_identifier} :
      hit(PADDR, OFF_MB_DLC) ? {28'h0000000, head.dlc} :
      hit(PADDR, OFF_MB_DLO) ? head.data[31:0] :
      hit(PADDR, OFF_MB_DHI) ? head.data[63:32] :
      filt_hit               ? swap_bytes(filt_word ? sel_bytes[31:0] : sel_bytes[63:32]) :
                               ZERO32;

   // ******************************************************
   // acceptance filtering
   // ******************************************************
   // filter word: base id, rtr, ide, extended id, trailing zero
   wire [31:0]        frame_word = {FRM_IN.base_identifier, FRM_IN.rtr, FRM_IN.ide,
                                    FRM_IN.extended_identifier, 1'b0};
   wire [31:0]        care_word  = FRM_IN.ide ? 32'hFFFF_FFFF : CARE32_STD;
   logic [NUM_BANKS-1:0] bank_hit;

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++)
      begin : g_bank
         assign bank_hit[gb] = bank_active_reg[gb]
                            && bank_match(filter_bytes_reg[gb], bank_scale_reg[gb],
                                          low_list_reg[gb], high_list_reg[gb],
                                          frame_word, care_word);
      end
   endgenerate

   wire               accept     = FRM_VALID && (|bank_hit);

   // ******************************************************
   // fifo control
   // ******************************************************
   wire               fifo_full  = (count_reg == CNT_THREE);
   // a release in the same cycle frees a slot, so no overrun then
   wire               overrun    = accept && fifo_full && !release_cmd;
   wire               do_store   = accept && !overrun;
   wire               do_shift   = release_cmd && (count_reg != CNT_EMPTY);
   wire [1:0]         after_rel  = do_shift ? count_reg - 2'h1 : count_reg;
   wire [1:0]         count_next = do_store ? after_rel + 2'h1 : after_rel;
   wire               full_set   = do_store && (count_next == CNT_THREE);

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         count_reg <= CNT_EMPTY;
         for (int i = 0; i < FIFO_DEPTH; i++)
            entry_reg[i] <= '0;
      end
      else
      begin
         count_reg <= count_next;
         for (int i = 0; i < FIFO_DEPTH; i++)
         begin
            if (do_store && (after_rel == 2'(i)))
               entry_reg[i] <= FRM_IN;
            else if (overrun && !lock_reg && (i == FIFO_DEPTH - 1))
               entry_reg[i] <= FRM_IN;
            else if (do_shift && (i < FIFO_DEPTH - 1))
               entry_reg[i] <= entry_reg[i + 1];
         end
         // lock set: entries untouched on overrun
      end
   end

   // ******************************************************
   // flags and interrupt outputs
   // ******************************************************
   wire clr_full = wr_done && hit(PADDR, OFF_RFR) && PWDATA[RFR_FULL_BIT];
   wire clr_ovr  = wr_done && hit(PADDR, OFF_RFR) && PWDATA[RFR_OVR_BIT];

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         full_flag_reg    <= 1'b0;
         overrun_flag_reg <= 1'b0;
         IRQ_PENDING      <= 1'b0;
         IRQ_FULL         <= 1'b0;
         IRQ_OVERRUN      <= 1'b0;
      end
      else
      begin
         // set beats a write-one clear in the same cycle
         full_flag_reg    <= full_set || (full_flag_reg && !clr_full);
         overrun_flag_reg <= overrun || (overrun_flag_reg && !clr_ovr);
         IRQ_PENDING      <= (count_next != CNT_EMPTY) && ier_reg[IER_PEND_BIT];
         IRQ_FULL         <= (full_set || (full_flag_reg && !clr_full))
                             && ier_reg[IER_FULL_BIT];
         IRQ_OVERRUN      <= (overrun || (overrun_flag_reg && !clr_ovr))
                             && ier_reg[IER_OVR_BIT];
      end
   end

   // ******************************************************
   // apb slave and configuration registers
   // ******************************************************
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         bus_state_reg <= BUS_IDLE;
         PREADY        <= 1'b0;
         PSLVERR       <= 1'b0;
         PRDATA        <= ZERO32;
      end
      else
      begin
         case (bus_state_reg)
            BUS_IDLE :
            begin
               if (PSEL && !PENABLE)
               begin
                  bus_state_reg <= BUS_ACCESS;
                  PREADY        <= 1'b1;
                  PSLVERR       <= !reg_hit;
                  PRDATA        <= PWRITE ? ZERO32 : rd_data;
               end
            end
            BUS_ACCESS :
            begin
               bus_state_reg <= BUS_IDLE;
               PREADY        <= 1'b0;
               PSLVERR       <= 1'b0;
               PRDATA        <= ZERO32;
            end
            default :
               bus_state_reg <= BUS_IDLE;
         endcase
      end
   end

   // filter bytes and bank layout are software's to keep stable while active
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         lock_reg        <= 1'b0;
         ier_reg         <= 3'h0;
         bank_active_reg <= '0;
         low_list_reg    <= '0;
         high_list_reg   <= '0;
         for (int b = 0; b < NUM_BANKS; b++)
         begin
            bank_scale_reg[b]   <= SCALE_FOUR8;
            filter_bytes_reg[b] <= 64'h0000_0000_0000_0000;
         end
      end
      else if (wr_done)
      begin
         if (hit(PADDR, OFF_MCR))
            lock_reg <= PWDATA[MCR_LOCK_BIT];
         if (hit(PADDR, OFF_IER))
            ier_reg <= PWDATA[2:0];
         if (hit(PADDR, OFF_FMR))
         begin
            low_list_reg  <= PWDATA[NUM_BANKS-1:0];
            high_list_reg <= PWDATA[FMR_HIGH_POS +: NUM_BANKS];
         end
         for (int b = 0; b < NUM_BANKS; b++)
         begin
            if (hit(PADDR, OFF_FCR))
            begin
               bank_active_reg[b] <= PWDATA[b*FCR_STRIDE];
               bank_scale_reg[b]  <= crf_scale_type'(PWDATA[b*FCR_STRIDE + 1 +: 2]);
            end
            if (filt_hit && (filt_bank == 3'(b)))
            begin
               if (filt_word)
                  filter_bytes_reg[b][31:0]  <= swap_bytes(PWDATA);
               else
                  filter_bytes_reg[b][63:32] <= swap_bytes(PWDATA);
            end
         end
      end
   end

   // ******************************************************
   // assertions
   // ******************************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   property p_first_store;
      (count_reg == CNT_EMPTY) && accept && !release_cmd
         |=> (count_reg == CNT_ONE) && (entry_reg[0] == $past(FRM_IN));
   endproperty
   a_first_store : assert property (p_first_store) else $error("first frame not stored");
   property p_release;
      (count_reg == CNT_TWO) && release_cmd && !accept
         |=> (count_reg == CNT_ONE) && (entry_reg[0] == $past(entry_reg[1]));
   endproperty
   a_release : assert property (p_release) else $error("release did not advance head");
   // frames come with gaps, so each single step is checked on its own
   property p_advance;
      ((count_reg == CNT_ONE) || (count_reg == CNT_TWO)) && accept && !release_cmd
         |=> count_reg == $past(count_reg) + 2'h1;
   endproperty
   a_advance : assert property (p_advance) else $error("count did not advance");
   property p_overrun;
      fifo_full && accept && !release_cmd |=> overrun_flag_reg && fifo_full;
   endproperty
   a_overrun : assert property (p_overrun) else $error("overrun not flagged");
   property p_overwrite;
      fifo_full && accept && !release_cmd && !lock_reg
         |=> (entry_reg[2] == $past(FRM_IN)) && $stable(entry_reg[0]);
   endproperty
   a_overwrite : assert property (p_overwrite) else $error("newest entry not replaced");
   property p_lock_keep;
      fifo_full && accept && !release_cmd && lock_reg |=> $stable(entry_reg[2]);
   endproperty
   a_lock_keep : assert property (p_lock_keep) else $error("locked fifo changed");
   property p_pend_irq;
      ($past(count_reg) == CNT_EMPTY) && (count_reg == CNT_ONE) && $past(ier_reg[IER_PEND_BIT])
         |-> IRQ_PENDING;
   endproperty
   a_pend_irq : assert property (p_pend_irq) else $error("pending irq missing");
   property p_full;
      (count_reg == CNT_TWO) && accept && !release_cmd
         |=> full_flag_reg && (IRQ_FULL == $past(ier_reg[IER_FULL_BIT]));
   endproperty
   a_full : assert property (p_full) else $error("full flag or irq wrong");
   property p_ovr_irq;
      overrun && ier_reg[IER_OVR_BIT] |=> IRQ_OVERRUN [*2];
   endproperty
   a_ovr_irq : assert property (p_ovr_irq) else $error("overrun irq missing");
   property p_inactive;
      FRM_VALID && (bank_active_reg == '0) |=> count_reg <= $past(count_reg);
   endproperty
   a_inactive : assert property (p_inactive) else $error("inactive banks accepted");

   c_fill    : cover property (accept ##[1:20] fifo_full);
   c_overrun : cover property (overrun && lock_reg);
   c_release : cover property (release_cmd && accept);
endmodule : crf_rx_fifo_filter

// ===== rtl/crf_pkg.sv
// package: register map, field layout, frame carrier for the can receive fifo and filters
package crf_pkg;
   localparam int          NUM_BANKS      = 6;
   localparam int          FIFO_DEPTH     = 3;
   localparam logic [11:0] OFF_MCR        = 12'h000;
   localparam logic [11:0] OFF_IER        = 12'h004;
   localparam logic [11:0] OFF_RFR        = 12'h008;
   localparam logic [11:0] OFF_FCR        = 12'h00C;
   localparam logic [11:0] OFF_FMR        = 12'h010;
   localparam logic [11:0] OFF_MB_ID      = 12'h020;
   localparam logic [11:0] OFF_MB_DLC     = 12'h024;
   localparam logic [11:0] OFF_MB_DLO     = 12'h028;
   localparam logic [11:0] OFF_MB_DHI     = 12'h02C;
   localparam logic [5:0]  FILT_REGION    = 6'h01;
   localparam int          MCR_LOCK_BIT   = 0;
   localparam int          IER_PEND_BIT   = 0;
   localparam int          IER_FULL_BIT   = 1;
   localparam int          IER_OVR_BIT    = 2;
   localparam int          RFR_FULL_BIT   = 3;
   localparam int          RFR_OVR_BIT    = 4;
   localparam int          RFR_REL_BIT    = 5;
   localparam int          FCR_STRIDE     = 4;
   localparam int          FMR_HIGH_POS   = 8;
   localparam logic [1:0]  CNT_EMPTY      = 2'h0;
   localparam logic [1:0]  CNT_ONE        = 2'h1;
   localparam logic [1:0]  CNT_TWO        = 2'h2;
   localparam logic [1:0]  CNT_THREE      = 2'h3;
   localparam logic [15:0] CARE16_STD     = 16'hFFF8;
   localparam logic [31:0] CARE32_STD     = 32'hFFF8_0000;
   localparam logic [31:0] ZERO32         = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      SCALE_FOUR8  = 2'b00,
      SCALE_MIXED  = 2'b01,
      SCALE_TWO16  = 2'b10,
      SCALE_ONE32  = 2'b11
   } crf_scale_type;

   typedef enum logic [1:0]
   {
      BUS_IDLE     = 2'b00,
      BUS_ACCESS   = 2'b01
   } crf_bus_state_type;

   typedef struct packed
   {
      logic        ide;
      logic        rtr;
      logic [10:0] base_identifier;
      logic [17:0] extended_identifier;
      logic [3:0]  dlc;
      logic [63:0] data;
   } crf_frame_type;

   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } crf_apb_req_type;
endpackage : crf_pkg

// ===== tb/crf_can_core_model.sv
// partner model: protocol core handing received frames to the fifo block
`timescale 1ns/1ps
module crf_can_core_model
   import crf_pkg::*;
(
   input  wire logic    REF_CLK,
   output logic         FRM_VALID,
   output crf_frame_type FRM_IN
);
   // ****************
   // frame delivery
   // ****************
   initial
   begin
      FRM_VALID = 1'b0;
      FRM_IN    = '0;
   end

   // only error-free frames are ever pulsed, one cycle each
   task automatic send(input logic [7:0] top, input logic [7:0] tag);
      @(posedge REF_CLK);
      FRM_VALID <= 1'b1;
      FRM_IN    <= {1'b0, 1'b0, top, 3'h5, 18'h0, 4'h8, 56'h0, tag};
      @(posedge REF_CLK);
      FRM_VALID <= 1'b0;
      // stale frame must not look valid
      FRM_IN    <= ~FRM_IN;
   endtask : send
endmodule : crf_can_core_model

// ===== tb/test_crf_rx_fifo_filter.sv
// testbench: fifo, overrun policies, filters and apb access of the receive block
`timescale 1ns/1ps
module test_crf_rx_fifo_filter
   import crf_pkg::*;
;
   logic          ref_clk = 1'b0;
   logic          rst_n   = 1'b0;
   logic          psel    = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite  = 1'b0;
   logic [11:0]   paddr   = 12'h000;
   logic [31:0]   pwdata  = 32'h0000_0000;
   logic [31:0]   prdata;
   logic          pready, pslverr, frm_valid, irq_p, irq_f, irq_o, err;
   crf_frame_type frm_in;
   logic [31:0]   rd;
   int            errors = 0;
   int            checks = 0;

   always #20 ref_clk = ~ref_clk;

   crf_rx_fifo_filter uut
   (
      .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .FRM_VALID(frm_valid), .FRM_IN(frm_in),
      .IRQ_PENDING(irq_p), .IRQ_FULL(irq_f), .IRQ_OVERRUN(irq_o)
   );

   crf_can_core_model core
   (
      .REF_CLK(ref_clk), .FRM_VALID(frm_valid), .FRM_IN(frm_in)
   );

   // ****************
   // shared tasks
   // ****************
   task automatic results();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // request held until pready is seen high at a rising edge; data taken at that edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         errors++;
         results();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rchk

   // drain three entries in order, then clear the sticky flags
   task automatic drain(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      rchk(OFF_MB_DLO, {24'h0, a});
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      rchk(OFF_MB_DLO, {24'h0, b});
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      rchk(OFF_MB_DLO, {24'h0, c});
      apb(1'b1, OFF_RFR, 32'h0000_0038);
      rchk(OFF_RFR, 32'h0000_0000);
   endtask : drain

   // ****************
   // scenarios
   // ****************
   task automatic t_list_accept();
      apb(1'b1, OFF_FMR, 32'h0000_0101);
      apb(1'b1, 12'h040, 32'hA5A5_A5A5);
      apb(1'b1, 12'h044, 32'h0000_0000);
      apb(1'b1, OFF_IER, 32'h0000_0007);
      core.send(8'hA5, 8'h01);
      rchk(OFF_RFR, 32'h0000_0000);
      apb(1'b1, OFF_FCR, 32'h0000_0001);
      core.send(8'h3C, 8'h09);
      rchk(OFF_RFR, 32'h0000_0000);
      chk({31'h0, irq_p}, 32'h0000_0000);
      core.send(8'hA5, 8'h01);
      rchk(OFF_RFR, 32'h0000_0001);
      chk({31'h0, irq_p}, 32'h0000_0001);
   endtask : t_list_accept

   task automatic t_overrun(input logic lock, input logic [7:0] s);
      apb(1'b1, OFF_MCR, {31'h0, lock});
      if (lock)
         core.send(8'hA5, s);
      core.send(8'hA5, s + 8'h01);
      rchk(OFF_RFR, 32'h0000_0002);
      core.send(8'hA5, s + 8'h02);
      rchk(OFF_RFR, 32'h0000_000B);
      chk({31'h0, irq_f}, 32'h0000_0001);
      core.send(8'hA5, s + 8'h03);
      rchk(OFF_RFR, 32'h0000_001B);
      chk({31'h0, irq_o}, 32'h0000_0001);
      drain(s, s + 8'h01, lock ? s + 8'h02 : s + 8'h03);
   endtask : t_overrun

   task automatic t_mask_and_refuse();
      apb(1'b1, OFF_FCR, 32'h0000_0000);
      apb(1'b1, OFF_FMR, 32'h0000_0000);
      apb(1'b1, 12'h040, 32'hFF00_F0A0);
      apb(1'b1, 12'h044, 32'hFF00_FF00);
      apb(1'b1, OFF_FCR, 32'h0000_0001);
      core.send(8'hB7, 8'h20);
      rchk(OFF_RFR, 32'h0000_0000);
      core.send(8'hA7, 8'h21);
      rchk(OFF_RFR, 32'h0000_0001);
      rchk(OFF_MB_DLO, 32'h0000_0021);
      apb(1'b1, 12'h100, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h0000_0001);
      rchk(12'h100, 32'h0000_0000);
   endtask : t_mask_and_refuse

   // bank 1 alone: 32-bit mask, then mixed 16 plus 2x8 in list mode
   task automatic t_wide_scales();
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      apb(1'b1, OFF_FCR, 32'h0000_0000);
      apb(1'b1, OFF_FMR, 32'h0000_0000);
      apb(1'b1, 12'h048, 32'h0000_A05A);
      apb(1'b1, 12'h04C, 32'h0000_F8FF);
      apb(1'b1, OFF_FCR, 32'h0000_0070);
      core.send(8'h5B, 8'h30);
      core.send(8'h5A, 8'h31);
      rchk(OFF_RFR, 32'h0000_0001);
      rchk(OFF_MB_DLO, 32'h0000_0031);
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      apb(1'b1, OFF_FCR, 32'h0000_0000);
      apb(1'b1, OFF_FMR, 32'h0000_0202);
      apb(1'b1, 12'h048, 32'hA0C3_A05A);
      apb(1'b1, 12'h04C, 32'h3C3C_3C3C);
      apb(1'b1, OFF_FCR, 32'h0000_0030);
      rchk(OFF_FMR, 32'h0000_0202);
      rchk(OFF_FCR, 32'h0000_0030);
      core.send(8'h99, 8'h40);
      core.send(8'hC3, 8'h41);
      core.send(8'h3C, 8'h42);
      rchk(OFF_RFR, 32'h0000_0002);
      rchk(OFF_MB_DLO, 32'h0000_0041);
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      rchk(OFF_MB_DLO, 32'h0000_0042);
      apb(1'b1, OFF_RFR, 32'h0000_0020);
      rchk(OFF_RFR, 32'h0000_0000);
   endtask : t_wide_scales

   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(OFF_FCR, 32'h0000_0000);
      t_list_accept();
      t_overrun(1'b0, 8'h01);
      t_overrun(1'b1, 8'h11);
      t_mask_and_refuse();
      t_wide_scales();
      results();
   end
endmodule : test_crf_rx_fifo_filter
